//--- hdl/bfm_params.svh
// timing counts and register map of the boost fault supervisor
`ifndef BFM_PARAMS_SVH
`define BFM_PARAMS_SVH
`define BFM_CLK_HZ          25000000
`define BFM_OVLD_MS         30
`define BFM_PULSE_US        128
`define BFM_WDOG_S          32
`define BFM_CRUDE_S         32
`define BFM_OVLD_CYC        ((`BFM_CLK_HZ / 1000) * `BFM_OVLD_MS)
`define BFM_PULSE_CYC       ((`BFM_CLK_HZ / 1000000) * `BFM_PULSE_US)
`define BFM_WDOG_CYC        (`BFM_CLK_HZ * `BFM_WDOG_S)
`define BFM_CRUDE_CYC       (`BFM_CLK_HZ * `BFM_CRUDE_S)
`define BFM_OFF_CTRL        12'h000
`define BFM_OFF_STAT        12'h004
`define BFM_OFF_MASK        12'h008
`define BFM_CTRL_BOOST      0
`define BFM_CTRL_HIZ        1
`define BFM_CTRL_KICK       2
`define BFM_FLT_OVV         0
`define BFM_FLT_OVLD        1
`define BFM_FLT_BAT         2
`define BFM_FLT_WDOG        3
`define BFM_STS_BOOST       4
`define BFM_STS_HIZ         5
`define BFM_STS_LONG        6
`define BFM_STS_CRUDE       7
`endif

//--- hdl/bfm_pkg.sv
// types of the boost fault supervisor
package bfm_pkg;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_BOOST = 3'b010,
        ST_HIZ   = 3'b100
    } mode_type;
    typedef struct packed {
        mode_type    mode;
        logic        boostReq;
        logic        hizReq;
        logic [3:0]  flt;
        logic [3:0]  msk;
        logic        longMode;
        logic [31:0] ovldCnt;
        logic [31:0] wdogCnt;
        logic [31:0] crudeCnt;
        logic [15:0] pulseCnt;
        logic        statOe;
        logic        irq;
        logic        pready;
        logic [31:0] prdata;
    } state_type;
endpackage

//--- hdl/bfm_boost_fault_mode.sv
// boost fault supervision, hi-z mode and crude timer, with apb registers
//
// Behaviour
// - bus overvoltage stops boost, clears request, flags
// - restart needs new request or pin
// - overload counts as fault after 30 ms
// - overload fault stops boost, clears request, flags
// - overload fault blocks boost until cleared
// - battery out of range stops boost, flags
// - restart after battery fault needs request or pin
// - status pin released, one 128 us pulse
// - hi-z when hi-z request and pin idle
// - crude 32 s timer in low-battery hi-z
// - crude expiry enters 32 minute mode
// - long mode: hi-z under bus undervoltage
// - boost on pin or request bit
// - kick bit keeps boost; expiry faults
//
// Our own choices: the APB register port and the address map.
`timescale 1ns/1ps
`include "bfm_params.svh"
module bfm_boost_fault_mode #(
    parameter int unsigned OVLD_CYC  = `BFM_OVLD_CYC,
    parameter int unsigned WDOG_CYC  = `BFM_WDOG_CYC,
    parameter int unsigned CRUDE_CYC = `BFM_CRUDE_CYC,
    parameter int unsigned PULSE_CYC = `BFM_PULSE_CYC
) (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // analog comparators and pin
    input  wire logic        extBoostReq,
    input  wire logic        busOvervolt,
    input  wire logic        busOverload,
    input  wire logic        busUnderUvlo,
    input  wire logic        batOvervolt,
    input  wire logic        batUnderMin,
    input  wire logic        batUnderLow,
    // converter control
    output logic             boostOn,
    output logic             passLimit,
    output logic             hizOn,
    // open-drain status pin, driven low while enabled
    output logic             statOut,
    output logic             statOe,
    // interrupt
    output logic             irq
);
    // all state lives in one packed struct: mode, request bits, fault and
    // mask words, the long-mode flag, four counters, the pulse pin enable,
    // the interrupt flop and the apb answer flops
    // the overload, watchdog and crude counters are 32 bits wide so the full-length timer spans fit;
    // a smaller build may pass short spans as parameters instead
    // hazard: every counter but the pulse one restarts on leaving its mode, so a short dip
    // out of boost resets the overload and watchdog spans
    // long mode is left only by reset; software has no way to clear it
    // the kick bit is never stored, so a read of the control word shows 0 there
    // trade-off: one struct keeps reset simple at the cost of a wide register
    bfm_pkg::state_type s_q, s_d;

    logic       acc;       // apb access phase
    logic       wr;        // write this cycle
    logic [3:0] evt;       // fault events this cycle
    logic       boostOk;   // boost may run
    logic       hizWant;   // hi-z condition

    // apb decode; the slave answers with exactly one wait state, so
    // writes take effect on the second access cycle, reads return the state of the first
    // limitation: pslverr never rises, unmapped words read as zero
    assign acc = psel & penable;
    assign wr  = acc & pwrite;

    // read mux for the three words
    // the status word mixes sticky faults in the low nibble with live
    // mode bits above them; only the low nibble reacts to write-one-clear
    // the crude-timer bit reads as running while its counter is non-zero
    // unmapped offsets fall through to zero
    function automatic logic [31:0] rdMux(input logic [11:0] a, input bfm_pkg::state_type s);
        logic [31:0] r;
        r = 32'h0000_0000;
        if (a == `BFM_OFF_CTRL) begin
            r[`BFM_CTRL_BOOST] = s.boostReq;
            r[`BFM_CTRL_HIZ]   = s.hizReq;
        end else if (a == `BFM_OFF_STAT) begin
            r[3:0]             = s.flt;
            r[`BFM_STS_BOOST]  = (s.mode == bfm_pkg::ST_BOOST);
            r[`BFM_STS_HIZ]    = (s.mode == bfm_pkg::ST_HIZ);
            r[`BFM_STS_LONG]   = s.longMode;
            r[`BFM_STS_CRUDE]  = (s.crudeCnt != 32'h0000_0000);
        end else if (a == `BFM_OFF_MASK) begin
            r[3:0] = s.msk;
        end
        return r;
    endfunction

    // next state
    // order inside this process matters: host writes first, then the
    // counters, then the fault events, which overrule a same-cycle write
    // of the request bit or a clear of the fault word
    // the mode choice comes last so it sees the updated request and faults
    // evt holds only the faults raised in this cycle, never latched ones
    // pready is a one-cycle strobe; it is dropped by default every cycle
    // read data is captured when the wait state starts and then held
    always_comb begin
        s_d = s_q;
        evt = 4'h0;
        s_d.pready = 1'b0;
        if (acc && !s_q.pready) begin
            s_d.pready = 1'b1; // one wait state
            s_d.prdata = rdMux(paddr, s_q);
        end
        // host writes, taken on the access cycle
        // a write lands only with pready high, the edge the master samples
        // writes to unmapped offsets are dropped silently
        if (wr && s_q.pready) begin
            if (paddr == `BFM_OFF_CTRL) begin
                s_d.boostReq = pwdata[`BFM_CTRL_BOOST];
                s_d.hizReq   = pwdata[`BFM_CTRL_HIZ];
            end
            if (paddr == `BFM_OFF_STAT) begin
                s_d.flt = s_q.flt & ~pwdata[3:0]; // write one to clear
            end
            if (paddr == `BFM_OFF_MASK) begin
                s_d.msk = pwdata[3:0];
            end
        end
        // overload is only a fault once it persists
        // while the count is non-zero the pass switch limits the current,
        // so the load sees a soft limit before the hard stop
        if (s_q.mode == bfm_pkg::ST_BOOST && busOverload) begin
            s_d.ovldCnt = s_q.ovldCnt + 32'd1;
        end else begin
            s_d.ovldCnt = 32'h0000_0000;
        end
        // watchdog: kick restarts it; self-clearing, never stored
        // the span starts afresh on every entry into boost, so software
        // must keep kicking for as long as it wants the bus supplied
        if (s_q.mode != bfm_pkg::ST_BOOST ||
            (wr && s_q.pready && paddr == `BFM_OFF_CTRL && pwdata[`BFM_CTRL_KICK])) begin
            s_d.wdogCnt = 32'h0000_0000;
        end else begin
            s_d.wdogCnt = s_q.wdogCnt + 32'd1;
        end
        if (s_q.mode == bfm_pkg::ST_BOOST) begin
            evt[`BFM_FLT_OVV]  = busOvervolt;
            evt[`BFM_FLT_OVLD] = (s_q.ovldCnt >= OVLD_CYC - 1);
            evt[`BFM_FLT_BAT]  = batOvervolt | batUnderMin;
            evt[`BFM_FLT_WDOG] = (s_q.wdogCnt >= WDOG_CYC - 1);
        end
        // events beat a same-cycle clear
        // so a fault raised while software clears is never lost
        s_d.flt = s_d.flt | evt;
        // any boost fault drops the request bit, so a restart needs a new write or the pin
        if (evt != 4'h0) begin
            s_d.boostReq = 1'b0;
        end
        // one pulse only on a fresh event, not while it stays latched
        // the pin is open drain: enable high pulls it low for the pulse,
        // otherwise it is released; a new kind of fault during a pulse
        // restarts the span rather than adding a second pulse
        if ((evt & ~s_q.flt) != 4'h0) begin
            s_d.pulseCnt = 16'(PULSE_CYC);
        end else if (s_q.pulseCnt != 16'h0000) begin
            s_d.pulseCnt = s_q.pulseCnt - 16'd1;
        end
        s_d.statOe = (s_d.pulseCnt != 16'h0000);
        // crude timer in hi-z with a low battery
        // it probes whether a host is still present; once it expires the
        // block stays in long mode and the crude timer stays off
        // a battery that recovers before expiry restarts the count at zero
        if (s_q.mode == bfm_pkg::ST_HIZ && batUnderLow && !s_q.longMode) begin
            s_d.crudeCnt = s_q.crudeCnt + 32'd1;
            if (s_q.crudeCnt >= CRUDE_CYC - 1) begin
                s_d.longMode = 1'b1;
                s_d.crudeCnt = 32'h0000_0000;
            end
        end else begin
            s_d.crudeCnt = 32'h0000_0000;
        end
        // mode choice; overload fault blocks until software clears it
        // hi-z wins over boost; in long mode a bus below lockout forces hi-z
        // whatever the request bit says
        // any event this cycle keeps boost off, even with the pin still up
        // limitation: no soft-start sequencing, boostOn rises at once
        hizWant = (s_q.hizReq && !extBoostReq) ||
                  (s_q.longMode && busUnderUvlo);
        boostOk = (evt == 4'h0) && !s_d.flt[`BFM_FLT_OVLD] &&
                  (s_d.boostReq || extBoostReq);
        // a bus overvoltage or battery fault caught with the pin still up restarts only once the condition is gone
        if (hizWant) begin
            s_d.mode = bfm_pkg::ST_HIZ;
        end else if (boostOk && (s_q.mode == bfm_pkg::ST_BOOST || (!busOvervolt &&
                     !batOvervolt && !batUnderMin))) begin
            s_d.mode = bfm_pkg::ST_BOOST;
        end else begin
            s_d.mode = bfm_pkg::ST_IDLE;
        end
        s_d.irq = ((s_d.flt & s_d.msk) != 4'h0);
    end

    // state register
    // synchronous reset puts every field at zero and the mode at idle,
    // which also leaves the status pin released
    always_ff @(posedge mclk) begin
        if (rst) begin
            s_q <= '{mode: bfm_pkg::ST_IDLE, default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    // outputs; each but passLimit is a flop of the state, a constant or a direct decode of the
    // one-hot mode; passLimit alone puts a 32-bit compare between a flop and a pin
    // statOut stays low: the pin is only ever pulled, never driven high
    // passLimit follows the overload count, zero from the second cycle outside boost
    assign pready    = s_q.pready;
    assign prdata    = s_q.prdata;
    assign pslverr   = 1'b0;
    assign boostOn   = (s_q.mode == bfm_pkg::ST_BOOST);
    assign hizOn     = (s_q.mode == bfm_pkg::ST_HIZ);
    assign passLimit = (s_q.ovldCnt != 32'h0000_0000);
    assign statOut   = 1'b0;
    assign statOe    = s_q.statOe;
    assign irq       = s_q.irq;

    // checks on the fault paths, the pulse and the mode choice
    // each watches the state that this module drives
    // spans are taken from the parameters, so short bench values work
    // the pulse check needs a pulse span of at least eight cycles
    AST_OVV_STOP: assert property (@(posedge mclk) disable iff (rst)
        boostOn && busOvervolt |=> !boostOn && s_q.flt[0] && !s_q.boostReq)
        else $error("overvoltage did not stop boost");
    AST_OVLD_TIME: assert property (@(posedge mclk) disable iff (rst)
        boostOn && busOverload && s_q.ovldCnt < OVLD_CYC - 1 && !busOvervolt |=> !s_q.flt[1] || $past(s_q.flt[1]))
        else $error("overload fault too early");
    AST_OVLD_STOP: assert property (@(posedge mclk) disable iff (rst)
        $rose(s_q.flt[1]) |-> !boostOn && !s_q.boostReq)
        else $error("overload fault left boost on");
    AST_OVLD_HOLD: assert property (@(posedge mclk) disable iff (rst)
        s_q.flt[1] |-> !boostOn)
        else $error("boost with overload fault latched");
    AST_BAT_STOP: assert property (@(posedge mclk) disable iff (rst)
        boostOn && (batOvervolt || batUnderMin) |=> !boostOn && s_q.flt[2])
        else $error("battery fault did not stop boost");
    AST_PULSE: assert property (@(posedge mclk) disable iff (rst)
        $rose(statOe) |-> statOe [*8])
        else $error("status pulse too short");
    AST_HIZ: assert property (@(posedge mclk) disable iff (rst)
        s_q.hizReq && !extBoostReq |=> hizOn)
        else $error("hi-z not entered");
    AST_LONG: assert property (@(posedge mclk) disable iff (rst)
        s_q.longMode && busUnderUvlo |=> hizOn)
        else $error("long mode hi-z missed");
    AST_ONE_PULSE: assert property (@(posedge mclk) disable iff (rst)
        statOe && s_q.pulseCnt > 16'd1 && $stable(s_q.flt) |=> statOe)
        else $error("pulse cut short");
    // watchdog, crude timer, restart, bus and pulse span checks
    AST_WDOG_STOP: assert property (@(posedge mclk) disable iff (rst)
        boostOn && s_q.wdogCnt >= WDOG_CYC - 1 |=> !boostOn && s_q.flt[3])
        else $error("watchdog expiry left boost on");
    AST_CRUDE_RUN: assert property (@(posedge mclk) disable iff (rst)
        hizOn && batUnderLow && !s_q.longMode && s_q.crudeCnt < CRUDE_CYC - 1 |=>
        s_q.crudeCnt == $past(s_q.crudeCnt) + 32'd1)
        else $error("crude timer did not count");
    AST_CRUDE_END: assert property (@(posedge mclk) disable iff (rst)
        hizOn && batUnderLow && !s_q.longMode && s_q.crudeCnt >= CRUDE_CYC - 1 |=>
        s_q.longMode && s_q.crudeCnt == 32'h0000_0000)
        else $error("crude expiry did not enter long mode");
    AST_REQ_BOOST: assert property (@(posedge mclk) disable iff (rst)
        !boostOn && !hizOn && s_q.boostReq && !s_q.hizReq && !s_q.flt[1] &&
        !s_q.longMode && !(wr && s_q.pready) && !busOvervolt && !batOvervolt &&
        !batUnderMin |=> boostOn)
        else $error("request bit did not start boost");
    AST_PIN_BOOST: assert property (@(posedge mclk) disable iff (rst)
        !boostOn && !hizOn && extBoostReq && !s_q.flt[1] && !s_q.longMode &&
        !busOvervolt && !batOvervolt && !batUnderMin |=> boostOn)
        else $error("pin did not start boost");
    AST_NO_RESTART: assert property (@(posedge mclk) disable iff (rst)
        !boostOn && !s_q.boostReq && !extBoostReq && !(wr && s_q.pready) |=> !boostOn)
        else $error("boost started without request");
    AST_PREADY: assert property (@(posedge mclk) disable iff (rst)
        pready |=> !pready)
        else $error("pready held longer than one cycle");
    AST_PULSE_LOAD: assert property (@(posedge mclk) disable iff (rst)
        $rose(statOe) |-> s_q.pulseCnt == 16'(PULSE_CYC))
        else $error("status pulse span wrong");

    // coverage of the main scenarios
    // boost entry, overload fault, hi-z entry and long mode
    COV_BOOST: cover property (@(posedge mclk) $rose(boostOn));
    COV_OVLD:  cover property (@(posedge mclk) $rose(s_q.flt[1]));
    COV_HIZ:   cover property (@(posedge mclk) $rose(hizOn));
    COV_LONG:  cover property (@(posedge mclk) $rose(s_q.longMode));
endmodule

//--- bench/bfm_host_model.sv
// apb host processor model for the boost fault supervisor
`timescale 1ns/1ps
module bfm_host_model (
    // apb master side
    input  wire logic        mclk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata,
    input  wire logic        pready,
    input  wire logic [31:0] prdata
);
    logic hung = 1'b0; // set when a transfer never completes
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0000_0000;
    end
    // one transfer; kicks, requests and clears all go through here
    task xfer(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge mclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) hung = 1'b1;
        q = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
        // released lines show stale-looking garbage, not the old value
        paddr   <= ~a;
        pwdata  <= ~d;
    endtask
endmodule

//--- bench/tb_top.sv
// self-checking bench of the boost fault supervisor
`timescale 1ns/1ps
`include "bfm_params.svh"
module tb_top;
    localparam int OV = 20; // shortened overload count
    localparam int PU = 8;  // shortened pulse length
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic        psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, d;
    logic [6:0]  ana = 7'h00; // pin, then the six comparators
    logic        boostOn, passLimit, hizOn, statOut, statOe, irq;
    logic [4:0]  outs;
    int          n_fail = 0;
    int          checked = 0;
    int          seed = 32'h97CC0A3E;
    assign outs = {irq, statOe, hizOn, passLimit, boostOn};
    initial forever #20 mclk = ~mclk;
    bfm_host_model host (.mclk(mclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata));
    bfm_boost_fault_mode #(.OVLD_CYC(OV), .WDOG_CYC(50), .CRUDE_CYC(50), .PULSE_CYC(PU)) uut (
        .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .extBoostReq(ana[0]), .busOvervolt(ana[1]),
        .busOverload(ana[2]), .busUnderUvlo(ana[3]), .batOvervolt(ana[4]),
        .batUnderMin(ana[5]), .batUnderLow(ana[6]), .boostOn(boostOn),
        .passLimit(passLimit), .hizOn(hizOn), .statOut(statOut), .statOe(statOe), .irq(irq));
    task stop_test;
        if (host.hung) n_fail++;
        if (n_fail == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            n_fail++;
        end
    endtask
    task wr(input logic [11:0] a, input logic [31:0] v);
        logic [31:0] q;
        host.xfer(1'b1, a, v, q);
    endtask
    task rdchk(input string nm, input logic [11:0] a, input logic [31:0] e);
        logic [31:0] q;
        host.xfer(1'b0, a, 32'h0, q);
        chk(nm, e, q);
    endtask
    // bounded wait for one output level, sampled at the settled falling edge
    task waitFor(input int i, input logic v, input int lim);
        int n;
        n = 0;
        do begin
            @(negedge mclk);
            n++;
        end while (outs[i] !== v && n < lim);
        chk($sformatf("out%0d", i), {31'h0, v}, {31'h0, outs[i]});
    endtask
    // one boost fault of kind k, pulse, irq, clear and restart
    task fault(input int k);
        int b;
        int f;
        int n;
        b = (k == 0) ? 1 : (k == 1) ? 2 : k + 2;
        f = (k > 2) ? 2 : k;
        wr(`BFM_OFF_CTRL, 32'h1);
        waitFor(0, 1'b1, 20);
        @(posedge mclk);
        ana[b] <= 1'b1;
        if (k == 1) begin
            waitFor(1, 1'b1, 5);
            repeat (OV - 5) @(negedge mclk);
            chk("boost in limit", 32'h1, {31'h0, boostOn});
        end
        waitFor(0, 1'b0, 12);
        n = 0;
        repeat (PU + 10) begin
            n += (statOe === 1'b1);
            @(negedge mclk);
        end
        chk("pulse length", PU, n);
        rdchk("status", `BFM_OFF_STAT, 32'h1 << f);
        rdchk("ctrl", `BFM_OFF_CTRL, 32'h0);
        wr(`BFM_OFF_MASK, 32'h1 << f);
        waitFor(4, 1'b1, 5);
        wr(`BFM_OFF_MASK, 32'h0);
        waitFor(4, 1'b0, 5);
        @(posedge mclk);
        ana[b] <= 1'b0;
        repeat (5) @(negedge mclk);
        chk("no restart", 32'h0, {31'h0, boostOn});
        if (k == 1) begin
            wr(`BFM_OFF_CTRL, 32'h1);
            repeat (5) @(negedge mclk);
            chk("blocked", 32'h0, {31'h0, boostOn});
            wr(`BFM_OFF_CTRL, 32'h0);
        end
        wr(`BFM_OFF_STAT, 32'h1 << f);
        rdchk("cleared", `BFM_OFF_STAT, 32'h0);
        @(posedge mclk);
        ana[0] <= (k == 3);
        if (k != 3) wr(`BFM_OFF_CTRL, 32'h1);
        waitFor(0, 1'b1, 20);
        @(posedge mclk);
        ana[0] <= 1'b0;
        wr(`BFM_OFF_CTRL, 32'h0);
        waitFor(0, 1'b0, 20);
    endtask
    initial begin
        repeat (100000) @(posedge mclk);
        n_fail++;
        stop_test;
    end
    initial begin
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        chk("outs at reset", 32'h0, {27'h0, outs});
        chk("pin drive and error", 32'h0, {30'h0, statOut, pslverr});
        rdchk("status", `BFM_OFF_STAT, 32'h0);
        repeat (8) begin
            d = $random(seed);
            wr(`BFM_OFF_MASK, d);
            rdchk("mask", `BFM_OFF_MASK, {28'h0, d[3:0]});
            wr(12'h00C, d);
            rdchk("unmapped", 12'h00C, 32'h0);
        end
        wr(`BFM_OFF_MASK, 32'h0);
        for (int k = 0; k < 4; k++) fault(k);
        // kicks hold boost past the watchdog span, then it expires
        wr(`BFM_OFF_CTRL, 32'h1);
        repeat (4) begin
            repeat (30) @(posedge mclk);
            wr(`BFM_OFF_CTRL, 32'h5);
        end
        rdchk("kick self clears", `BFM_OFF_CTRL, 32'h1);
        waitFor(0, 1'b0, 80);
        rdchk("status", `BFM_OFF_STAT, 32'h8);
        wr(`BFM_OFF_STAT, 32'hF);
        // hi-z, pin override, crude timer and long mode
        wr(`BFM_OFF_CTRL, 32'h2);
        waitFor(2, 1'b1, 10);
        @(posedge mclk);
        ana[0] <= 1'b1;
        waitFor(2, 1'b0, 10);
        @(posedge mclk);
        ana <= 7'h40;
        waitFor(2, 1'b1, 30);
        repeat (80) @(posedge mclk);
        rdchk("long mode", `BFM_OFF_STAT, 32'h60);
        wr(`BFM_OFF_CTRL, 32'h0);
        waitFor(2, 1'b0, 10);
        @(posedge mclk);
        ana <= 7'h08;
        waitFor(2, 1'b1, 10);
        stop_test;
    end
endmodule
